// ---- verilog/external_space_ram_page_pkg.sv ----
package external_space_ram_page_pkg;
  // Geometry of the external-space RAM
  localparam int unsigned RAM_BYTES = 512;
  localparam int unsigned RAM_AW = 9;
  localparam logic [15:0] ALIAS_STRIDE = 16'h0200;
  // Special-function register map
  localparam logic [7:0] PAGE_REG_ADDR = 8'haa;
  localparam logic [7:0] PAGE_REG_RESET = 8'h00;
  // Page select field position within the page register
  localparam int unsigned PAGE_FIELD_POS = 0;
  localparam logic [7:0] PAGE_FIELD_MASK = 8'h01;
  // Read data of the page register and the RAM after reset
  localparam logic [7:0] RDATA_RESET = 8'h00;
  // Redirected write address after reset
  localparam logic [15:0] FLASH_ADDR_RESET = 16'h0000;
endpackage : external_space_ram_page_pkg

// ---- verilog/external_space_ram_page_access.sv ----
`timescale 1ns/1ps
module external_space_ram_page_access (
  input wire logic clock, // System clock, 250 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic xmove_req, // External move strobe, one cycle
  input wire logic xmove_write, // 1 write, 0 read
  input wire logic xmove_short, // 1 8-bit operand, 0 16-bit pointer
  input wire logic [15:0] data_pointer_16bit, // Pointer address
  input wire logic [7:0] xmove_operand, // 8-bit indirect operand
  input wire logic [7:0] xmove_wdata, // Write data
  input wire logic flash_write_enable, // Flash write enable bit
  input wire logic sfr_wr, // Special register write strobe
  input wire logic sfr_rd, // Special register read strobe
  input wire logic [7:0] sfr_addr, // Special register address
  input wire logic [7:0] sfr_wdata, // Special register write data
  output logic [7:0] sfr_rdata, // Special register read data
  output logic sfr_hit, // Read address matched page register
  output logic [7:0] xmove_rdata, // RAM read data
  output logic xmove_rvalid, // Read data valid, one cycle
  output logic flash_wr_req, // Move write redirected to flash
  output logic [15:0] flash_wr_addr, // Redirected write address
  output logic [7:0] flash_wr_data // Redirected write data
);

  // Whole block state in one word; the RAM array stays outside it
  typedef struct packed {
    logic [7:0] external_space_ram_page_select_ff; // Page register, bit 0 used
    logic [7:0] sfr_rdata_ff; // Register read data
    logic sfr_hit_ff; // Read hit the page register
    logic [7:0] rdata_ff; // Last RAM byte read
    logic rvalid_ff; // RAM read answer strobe
    logic fwr_ff; // Flash write request strobe
    logic [15:0] faddr_ff; // Last redirected address
    logic [7:0] fdata_ff; // Last redirected data
  } state_t;

  // Registered state and its next value
  state_t st_ff;
  state_t nxt_st;

  // Storage array, no reset so it maps to a plain RAM
  // Contents are unknown until software writes them
  logic [7:0] external_space_ram [0:external_space_ram_page_pkg::RAM_BYTES-1];

  // Address decode signals
  logic [external_space_ram_page_pkg::RAM_AW-1:0] ram_addr; // Decoded RAM byte
  logic [external_space_ram_page_pkg::RAM_AW-1:0] short_addr; // Page plus operand
  logic [external_space_ram_page_pkg::RAM_AW-1:0] long_addr; // Low pointer bits
  logic page_select_field; // Page bit in use
  logic ram_we; // RAM write this edge

  // Register strobes
  logic page_wr_hit; // Write aimed at the page register
  logic page_rd_hit; // Read aimed at the page register
  logic page_rd_miss; // Read of any other register

  // Move strobes
  logic move_rd; // Move read taken this edge
  logic move_flash_wr; // Move write sent to flash

  // Values feeding the state
  logic [7:0] page_wdata_kept; // Written byte, unused bits cleared
  logic [7:0] ram_rbyte; // Byte at the decoded address
  logic [15:0] flash_addr_short; // Redirect address, operand mode
  logic [15:0] flash_addr; // Redirect address as presented

  // Current page bit
  assign page_select_field =
    st_ff.external_space_ram_page_select_ff[external_space_ram_page_pkg::PAGE_FIELD_POS];

  // Operand mode: page bit on top of the operand byte
  // Only one page bit exists, so two pages of 256 bytes
  assign short_addr = {page_select_field, xmove_operand};

  // Pointer mode: bits above the RAM width never reach the decode,
  // which is what makes the RAM repeat every 0x0200 bytes
  assign long_addr = data_pointer_16bit[external_space_ram_page_pkg::RAM_AW-1:0];

  // Address formation by move mode
  always_comb begin
    if (xmove_short) begin
      ram_addr = short_addr;
    end else begin
      ram_addr = long_addr;
    end
  end

  // Register decode; only one address is mapped here
  assign page_wr_hit = sfr_wr && (sfr_addr == external_space_ram_page_pkg::PAGE_REG_ADDR);
  assign page_rd_hit = sfr_rd && (sfr_addr == external_space_ram_page_pkg::PAGE_REG_ADDR);
  assign page_rd_miss = sfr_rd && !page_rd_hit;

  // Move decode; RAM is the default target
  assign move_rd = xmove_req && !xmove_write;
  assign move_flash_wr = xmove_req && xmove_write && flash_write_enable;

  // Flash only takes writes when enabled; reads never leave RAM
  assign ram_we = xmove_req && xmove_write && !flash_write_enable;

  // Unused upper page bits are dropped so they read back as zero
  assign page_wdata_kept = sfr_wdata & external_space_ram_page_pkg::PAGE_FIELD_MASK;

  // Array read; a same-cycle write is seen only on the next read
  assign ram_rbyte = external_space_ram[ram_addr];

  // Operand-mode redirect keeps the page bit above the operand
  assign flash_addr_short = {7'h00, page_select_field, xmove_operand};

  // Pointer-mode redirect passes the full pointer on to flash,
  // since flash is not limited to the RAM's width
  always_comb begin
    if (xmove_short) begin
      flash_addr = flash_addr_short;
    end else begin
      flash_addr = data_pointer_16bit;
    end
  end

  // RAM write port
  always_ff @(posedge clock) begin
    if (ram_we) begin
      external_space_ram[ram_addr] <= xmove_wdata;
    end
  end

  // Next-state logic; strobes fall back to zero every cycle
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid_ff = 1'b0;
    nxt_st.fwr_ff = 1'b0;
    nxt_st.sfr_hit_ff = 1'b0;

    // Page register write
    if (page_wr_hit) begin
      nxt_st.external_space_ram_page_select_ff = page_wdata_kept;
    end

    // Register read; unmapped addresses return zero
    if (page_rd_hit) begin
      nxt_st.sfr_rdata_ff = st_ff.external_space_ram_page_select_ff;
      nxt_st.sfr_hit_ff = 1'b1;
    end else if (page_rd_miss) begin
      nxt_st.sfr_rdata_ff = external_space_ram_page_pkg::RDATA_RESET;
    end

    // Reads always come from RAM; flash enable only redirects writes
    if (move_rd) begin
      nxt_st.rdata_ff = ram_rbyte;
      nxt_st.rvalid_ff = 1'b1;
    end

    // Redirected write; the RAM write port is held off meanwhile
    if (move_flash_wr) begin
      nxt_st.fwr_ff = 1'b1;
      nxt_st.faddr_ff = flash_addr;
      nxt_st.fdata_ff = xmove_wdata;
    end
  end

  // State register; the RAM array is left out of reset on purpose
  always_ff @(posedge clock) begin
    if (rst) begin
      // Page register
      st_ff.external_space_ram_page_select_ff <= external_space_ram_page_pkg::PAGE_REG_RESET;
      // Register read path
      st_ff.sfr_rdata_ff <= external_space_ram_page_pkg::RDATA_RESET;
      st_ff.sfr_hit_ff <= 1'b0;
      // Move read path
      st_ff.rdata_ff <= external_space_ram_page_pkg::RDATA_RESET;
      st_ff.rvalid_ff <= 1'b0;
      // Flash redirect path
      st_ff.fwr_ff <= 1'b0;
      st_ff.faddr_ff <= external_space_ram_page_pkg::FLASH_ADDR_RESET;
      st_ff.fdata_ff <= external_space_ram_page_pkg::RDATA_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Register read outputs, straight from flops
  assign sfr_rdata = st_ff.sfr_rdata_ff;
  assign sfr_hit = st_ff.sfr_hit_ff;

  // Move read outputs, straight from flops
  assign xmove_rdata = st_ff.rdata_ff;
  assign xmove_rvalid = st_ff.rvalid_ff;

  // Flash redirect outputs, straight from flops
  // Address and data hold until the next redirect
  assign flash_wr_req = st_ff.fwr_ff;
  assign flash_wr_addr = st_ff.faddr_ff;
  assign flash_wr_data = st_ff.fdata_ff;

endmodule : external_space_ram_page_access

// ---- testbench/external_space_ram_chk.sv ----
`timescale 1ns/1ps
module external_space_ram_chk (
  input wire logic clock, input wire logic rst, // Clock, reset
  input wire logic xmove_req, input wire logic xmove_write, // Move
  input wire logic xmove_short, input wire logic flash_write_enable, // Mode
  input wire logic [7:0] xmove_operand, input wire logic [7:0] xmove_wdata,
  input wire logic xmove_rvalid, input wire logic flash_wr_req, // Answers
  input wire logic [15:0] flash_wr_addr, input wire logic [7:0] flash_wr_data
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Redirected write taken this edge
  wire logic fw = xmove_req && xmove_write && flash_write_enable;
  a_read_answers: assert property (xmove_req && !xmove_write |=> xmove_rvalid && !flash_wr_req) else $error("read lost");
  a_ram_default: assert property (xmove_req && xmove_write && !flash_write_enable |=> !flash_wr_req) else $error("stray flash");
  a_flash_redirect: assert property (fw |=> flash_wr_req && !xmove_rvalid) else $error("no redirect");
  a_flash_data: assert property (fw |=> flash_wr_data == $past(xmove_wdata)) else $error("bad data");
  a_short_low: assert property (fw && xmove_short |=> flash_wr_addr[7:0] == $past(xmove_operand)) else $error("bad low");
  a_short_high: assert property (fw && xmove_short |=> flash_wr_addr[15:9] == 7'h00) else $error("bad high");
endmodule : external_space_ram_chk
bind external_space_ram_page_access external_space_ram_chk chk (.*);

// ---- testbench/core_model.sv ----
`timescale 1ns/1ps
module core_model (
  input wire logic clock, // Clock
  output logic xmove_req, output logic xmove_write, output logic xmove_short,
  output logic flash_write_enable, output logic [15:0] data_pointer_16bit,
  output logic [7:0] xmove_operand, output logic [7:0] xmove_wdata // Move
);
  initial {xmove_req, xmove_write, xmove_short, flash_write_enable} = 4'h0;
  // One move per call, held across exactly one taking edge
  task mv(input logic w, s, f, input logic [15:0] p, input logic [7:0] d);
    @(negedge clock);
    {xmove_req, xmove_write, xmove_short, flash_write_enable} = {1'b1, w, s, f};
    {data_pointer_16bit, xmove_operand, xmove_wdata} = {p, p[7:0], d};
    @(negedge clock);
    xmove_req = 1'b0;
    xmove_wdata = ~d; // Released bus must not look held
  endtask : mv
endmodule : core_model

// ---- testbench/external_space_ram_page_access_tb.sv ----
`timescale 1ns/1ps
module external_space_ram_page_access_tb;
  logic clock = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, sfr_hit, xmove_rvalid;
  logic xmove_req, xmove_write, xmove_short, flash_write_enable, flash_wr_req;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, xmove_rdata;
  logic [7:0] xmove_operand, xmove_wdata, flash_wr_data;
  logic [15:0] data_pointer_16bit, flash_wr_addr;
  int n_fail = 0, n_compared = 0, mem[int];
  always #2 clock = ~clock;
  external_space_ram_page_access uut (.*);
  core_model core (.*);
  task chk(input string n, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // Register cycle; read data lands one edge later
  task reg_acc(input logic w, input logic [7:0] a, d, e);
    @(negedge clock);
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {w, !w, a, d};
    @(negedge clock);
    {sfr_wr, sfr_rd} = 2'h0;
    if (!w) chk("sfr_rdata", e, sfr_rdata);
    if (!w) chk("sfr_hit", 16'(a == external_space_ram_page_pkg::PAGE_REG_ADDR), 16'(sfr_hit));
  endtask : reg_acc
  // Random mode; high pointer bits random to hit aliases
  task acc(input logic w, f, input logic [8:0] a, input logic [7:0] d);
    logic s;
    logic [15:0] p;
    s = 1'($urandom);
    p = {7'($urandom), a};
    if (s) reg_acc(1, 8'haa, {7'($urandom), a[8]}, 8'h00);
    core.mv(w, s, f, p, d);
    chk("move", {14'h0, w && f, !w}, {14'h0, flash_wr_req, xmove_rvalid});
    if (!w) chk("xmove_rdata", 16'(mem[a]), {8'h00, xmove_rdata});
    if (w && f) chk("flash_wr_addr", s ? {7'h00, a} : p, flash_wr_addr);
    if (w && f) chk("flash_wr_data", {8'h00, d}, {8'h00, flash_wr_data});
  endtask : acc
  task final_report;
    $display("Compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  initial begin
    logic [8:0] a;
    logic [7:0] d;
    void'($urandom(32'h8534));
    repeat (3) @(negedge clock);
    rst = 0;
    reg_acc(0, 8'haa, 8'h00, 8'h00);
    reg_acc(1, 8'haa, 8'hff, 8'h00);
    reg_acc(0, 8'haa, 8'h00, 8'h01);
    reg_acc(0, 8'hab, 8'h00, 8'h00);
    $display("Test page register done");
    for (int i = 0; i < 60; i++) begin
      a = 9'($urandom);
      d = 8'($urandom);
      acc(1, 0, a, d);
      mem[a] = d;
      acc(1, 1, a, ~d);
      acc(0, 1'($urandom), a, 8'h00);
    end
    $display("Test moves done");
    final_report;
  end
  // Watchdog far beyond the few hundred cycles needed
  initial begin
    #100000;
    n_fail++;
    final_report;
  end
endmodule : external_space_ram_page_access_tb
